/* File: rbt_pkg.sv */
/*
 Package for the reset/interrupt mask bank and button hold timer.
 Assumes a 125 MHz clock and byte-wide register access at 7-bit offsets.
*/
`default_nettype none
package rbt_pkg;
	localparam logic [6:0] OFS_RST_MASK_A = 7'h11;
	localparam logic [6:0] OFS_RST_MASK_B = 7'h12;
	localparam logic [6:0] OFS_TOP_MASK = 7'h13;
	localparam logic [6:0] OFS_BTN_CFG = 7'h14;
	localparam logic [6:0] OFS_BTN_STATE = 7'h15;
	localparam logic [7:0] RST_RST_MASK_A = 8'h30;
	localparam logic [7:0] RST_RST_MASK_B = 8'h02;
	localparam logic [7:0] RST_TOP_MASK = 8'ha5;
	localparam logic [7:0] RST_BTN_CFG = 8'h1f;
	localparam logic [7:0] RST_BTN_STATE = 8'h00;
	// Writable bits of each mask register
	localparam logic [7:0] WMASK_RST_A = 8'h30;
	localparam logic [7:0] WMASK_RST_B = 8'h02;
	localparam logic [7:0] WMASK_TOP = 8'ha5;
	localparam int BIT_FORCED_MASK = 5;
	localparam int BIT_REGFAULT_MASK = 4;
	localparam int BIT_OVERTEMP_MASK = 1;
	localparam int BIT_RESET_GRP = 7;
	localparam int BIT_MONITOR_GRP = 5;
	localparam int BIT_SUPPLY_GRP = 2;
	localparam int BIT_BUTTON_GRP = 0;
	localparam int BIT_DEBOUNCE_BYPASS = 7;
	localparam int BIT_HOLD_CLEAR = 6;
	localparam int BIT_BUTTON_LEVEL = 6;
	localparam int CLK_HZ = 125000000;
	localparam int DEBOUNCE_MS = 30;
	localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int SECOND_CYC = CLK_HZ;
endpackage : rbt_pkg
`default_nettype wire

/* File: rbt_debounce.sv */
/*
 Button debouncer: output follows the input once it has been stable
 for the given number of cycles, or on the next clock when bypassed.
 Assumes the button input is already synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rbt_debounce #(
	parameter int STABLE_CYC = 3750000
) (
	input wire logic clk, // Clock
	input wire logic rst, // Sync reset, active high
	input wire logic bypass, // 1 passes input through one register, unfiltered
	input wire logic btn_in, // Raw level, 0 while held
	output logic btn_out // Filtered level, 0 while held
);
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic out_reg;
	logic out_next;

	always_comb begin
		cnt_next = 32'h0;
		out_next = out_reg;
		if (bypass) begin
			out_next = btn_in;
		end else if (btn_in != out_reg) begin
			if (cnt_reg >= 32'(STABLE_CYC - 1)) begin
				out_next = btn_in;
			end else begin
				cnt_next = cnt_reg + 32'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= 32'h0;
			out_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_next;
			out_reg <= out_next;
		end
	end

	assign btn_out = out_reg;
endmodule : rbt_debounce
`default_nettype wire

/* File: rbt_regbank.sv */
/*
 Mask registers for reset causes and top-level interrupt groups, plus the
 power button hold timer that forces an emergency reset.
 Assumes a byte register port driven by an external serial host decoder,
 and event inputs synchronous to clk.
*/
//
// Functional notes
// R01 - Button-forced reset mask, bit 5, reset 1
// R02 - Regulator-fault reset mask, bit 4, reset 1
// R03 - Overtemperature reset mask at 0x12 bit 1
// R04 - Reset group mask bit 7, reset masked
// R05 - Monitor group mask bit 5, reset masked
// R06 - Supply source group mask bit 2
// R07 - Button group mask bit 0
// R08 - Debounce 30 ms unless bypass bit set
// R09 - Writing hold clear resets counter, self-clears
// R10 - Hold threshold seconds, 0..63, reset 31
// R11 - Status shows button level, 0 held
// R12 - Status shows held seconds, reset zero
// R13 - Threshold reached sets button-forced reset flag
// R14 - Critical temperature forces shutdown, sets flag
// R15 - Masked sources record flags, no interrupt
// R16 - Reserved zero; counter runs while held only
`timescale 1ns/1ps
`default_nettype none
module rbt_regbank #(
	parameter int SECOND_CYC = rbt_pkg::SECOND_CYC,
	parameter int DEBOUNCE_CYC = rbt_pkg::DEBOUNCE_CYC
) (
	input wire logic clk, // Clock, 125 MHz
	input wire logic rst, // Sync reset, active high
	input wire logic [6:0] reg_addr, // Register offset
	input wire logic reg_wr, // Write strobe, one cycle
	input wire logic [7:0] reg_wdata, // Write data
	output logic [7:0] reg_rdata, // Read data, registered
	input wire logic button_n, // Button pin, 0 while held
	input wire logic overtemp_event, // Critical temperature pulse
	input wire logic regfault_event, // Regulator fault reset pulse
	input wire logic monitor_group_pend, // Monitor group pending
	input wire logic supply_group_pend, // Supply group pending
	input wire logic button_group_pend, // Button group pending
	input wire logic flag_clear_forced, // Clear forced-reset flag
	input wire logic flag_clear_overtemp, // Clear overtemp flag
	input wire logic flag_clear_regfault, // Clear regfault flag
	output logic button_forced_reset_flag, // Forced by hold timer
	output logic overtemp_shutdown_flag, // Critical temp seen
	output logic regulator_fault_flag, // Regulator fault seen
	output logic emergency_reset, // Emergency reset/shutdown pulse
	output logic irq // Combined interrupt, active high
);
	logic [7:0] mask_a_reg, mask_a_next;
	logic [7:0] mask_b_reg, mask_b_next;
	logic [7:0] top_reg, top_next;
	logic [7:0] cfg_reg, cfg_next;
	logic [5:0] held_reg, held_next;
	logic [31:0] sec_reg, sec_next;
	logic fired_reg, fired_next;
	logic fco_reg, fco_next;
	logic ot_reg, ot_next;
	logic vr_reg, vr_next;
	logic erst_reg, erst_next;
	logic [7:0] rdata_reg, rdata_next;
	logic btn_db;
	logic trip;

	function automatic logic [7:0] wr_masked(input logic [7:0] old,
		input logic [7:0] data, input logic [7:0] wm);
		wr_masked = (old & ~wm) | (data & wm);
	endfunction : wr_masked

	////////////////////////////////////////////////////////////////////
	// Debounce
	rbt_debounce #(
		.STABLE_CYC(DEBOUNCE_CYC)
	) u_deb (
		.clk(clk),
		.rst(rst),
		.bypass(cfg_reg[rbt_pkg::BIT_DEBOUNCE_BYPASS]), // R08
		.btn_in(button_n),
		.btn_out(btn_db)
	);

	////////////////////////////////////////////////////////////////////
	// Registers
	always_comb begin
		mask_a_next = mask_a_reg;
		mask_b_next = mask_b_reg;
		top_next = top_reg;
		cfg_next = cfg_reg;
		// Self-clearing: a stored clear lasts exactly one cycle
		cfg_next[rbt_pkg::BIT_HOLD_CLEAR] = 1'b0; // R09
		if (reg_wr) begin
			case (reg_addr)
				rbt_pkg::OFS_RST_MASK_A: mask_a_next = wr_masked(mask_a_reg,
					reg_wdata, rbt_pkg::WMASK_RST_A); // R01 R02 R16
				rbt_pkg::OFS_RST_MASK_B: mask_b_next = wr_masked(mask_b_reg,
					reg_wdata, rbt_pkg::WMASK_RST_B); // R03 R16
				rbt_pkg::OFS_TOP_MASK: top_next = wr_masked(top_reg,
					reg_wdata, rbt_pkg::WMASK_TOP); // R04 R05 R06 R07 R16
				rbt_pkg::OFS_BTN_CFG: cfg_next = reg_wdata; // R08 R09 R10
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Hold timer
	// Threshold 0 trips as soon as the debounced button goes low
	assign trip = !btn_db && !fired_reg
		&& (held_reg >= cfg_reg[5:0]); // R10 R13

	always_comb begin
		held_next = held_reg;
		sec_next = sec_reg;
		fired_next = fired_reg;
		if (cfg_reg[rbt_pkg::BIT_HOLD_CLEAR] || btn_db) begin
			// Release or clear restarts the count and rearms the trip
			held_next = 6'h0; // R09 R16
			sec_next = 32'h0;
			fired_next = 1'b0;
		end else begin
			if (trip) begin
				fired_next = 1'b1;
			end
			if (sec_reg >= 32'(SECOND_CYC - 1)) begin
				sec_next = 32'h0;
				// Saturate rather than wrap past 63 s
				if (held_reg != 6'h3f) begin
					held_next = held_reg + 6'h1; // R16
				end
			end else begin
				sec_next = sec_reg + 32'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Flags, set wins over clear
	always_comb begin
		fco_next = trip | (fco_reg & ~flag_clear_forced); // R13
		ot_next = overtemp_event | (ot_reg & ~flag_clear_overtemp); // R14
		vr_next = regfault_event | (vr_reg & ~flag_clear_regfault);
		erst_next = trip | overtemp_event; // R13 R14
	end

	always_comb begin
		case (reg_addr)
			rbt_pkg::OFS_RST_MASK_A: rdata_next = mask_a_reg;
			rbt_pkg::OFS_RST_MASK_B: rdata_next = mask_b_reg;
			rbt_pkg::OFS_TOP_MASK: rdata_next = top_reg;
			rbt_pkg::OFS_BTN_CFG: rdata_next = cfg_reg;
			rbt_pkg::OFS_BTN_STATE: rdata_next = {1'b0, btn_db,
				held_reg}; // R11 R12 R16
			default: rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mask_a_reg <= rbt_pkg::RST_RST_MASK_A;
			mask_b_reg <= rbt_pkg::RST_RST_MASK_B;
			top_reg <= rbt_pkg::RST_TOP_MASK;
			cfg_reg <= rbt_pkg::RST_BTN_CFG;
			held_reg <= 6'h0;
			sec_reg <= 32'h0;
			fired_reg <= 1'b0;
			fco_reg <= 1'b0;
			ot_reg <= 1'b0;
			vr_reg <= 1'b0;
			erst_reg <= 1'b0;
			rdata_reg <= rbt_pkg::RST_BTN_STATE;
		end else begin
			mask_a_reg <= mask_a_next;
			mask_b_reg <= mask_b_next;
			top_reg <= top_next;
			cfg_reg <= cfg_next;
			held_reg <= held_next;
			sec_reg <= sec_next;
			fired_reg <= fired_next;
			fco_reg <= fco_next;
			ot_reg <= ot_next;
			vr_reg <= vr_next;
			erst_reg <= erst_next;
			rdata_reg <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Interrupt
	logic reset_grp;
	assign reset_grp = (fco_reg & ~mask_a_reg[rbt_pkg::BIT_FORCED_MASK])
		| (vr_reg & ~mask_a_reg[rbt_pkg::BIT_REGFAULT_MASK])
		| (ot_reg & ~mask_b_reg[rbt_pkg::BIT_OVERTEMP_MASK]); // R15
	assign irq = (reset_grp & ~top_reg[rbt_pkg::BIT_RESET_GRP])
		| (monitor_group_pend & ~top_reg[rbt_pkg::BIT_MONITOR_GRP])
		| (supply_group_pend & ~top_reg[rbt_pkg::BIT_SUPPLY_GRP])
		| (button_group_pend & ~top_reg[rbt_pkg::BIT_BUTTON_GRP]); // R15

	assign reg_rdata = rdata_reg;
	assign button_forced_reset_flag = fco_reg;
	assign overtemp_shutdown_flag = ot_reg;
	assign regulator_fault_flag = vr_reg;
	assign emergency_reset = erst_reg;

	////////////////////////////////////////////////////////////////////
	// Assertions
	property p_mask_a_reserved;
		@(posedge clk) disable iff (rst)
		(mask_a_reg & ~rbt_pkg::WMASK_RST_A) == 8'h00;
	endproperty
	a_mask_a_reserved: assert property (p_mask_a_reserved) // R16
		else $error("reserved mask bits set");

	property p_clear_self;
		@(posedge clk) disable iff (rst)
		cfg_reg[rbt_pkg::BIT_HOLD_CLEAR] |=>
			!cfg_reg[rbt_pkg::BIT_HOLD_CLEAR]
			|| $past(reg_wr && reg_addr == rbt_pkg::OFS_BTN_CFG
			&& reg_wdata[rbt_pkg::BIT_HOLD_CLEAR]);
	endproperty
	a_clear_self: assert property (p_clear_self) // R09
		else $error("hold clear did not self clear");

	property p_clear_zero;
		@(posedge clk) disable iff (rst)
		cfg_reg[rbt_pkg::BIT_HOLD_CLEAR] |=> held_reg == 6'h0;
	endproperty
	a_clear_zero: assert property (p_clear_zero) // R09
		else $error("held count not cleared");

	property p_release_zero;
		@(posedge clk) disable iff (rst)
		btn_db |=> held_reg == 6'h0;
	endproperty
	a_release_zero: assert property (p_release_zero) // R16
		else $error("held count not stopped on release");

	property p_trip_flag;
		@(posedge clk) disable iff (rst)
		trip |=> fco_reg && emergency_reset;
	endproperty
	a_trip_flag: assert property (p_trip_flag) // R13
		else $error("forced reset flag missing");

	property p_overtemp;
		@(posedge clk) disable iff (rst)
		overtemp_event |=> ot_reg && emergency_reset;
	endproperty
	a_overtemp: assert property (p_overtemp) // R14
		else $error("overtemp flag missing");

	property p_masked_quiet;
		@(posedge clk) disable iff (rst)
		(top_reg == 8'ha5) |-> !irq;
	endproperty
	a_masked_quiet: assert property (p_masked_quiet) // R15
		else $error("irq with all groups masked");

	property p_status_read;
		@(posedge clk) disable iff (rst)
		reg_addr == rbt_pkg::OFS_BTN_STATE |=>
			reg_rdata == {1'b0, $past(btn_db), $past(held_reg)};
	endproperty
	a_status_read: assert property (p_status_read) // R11 R12
		else $error("status readback wrong");

	c_trip: cover property (@(posedge clk) disable iff (rst) trip);
	c_irq: cover property (@(posedge clk) disable iff (rst) irq);
	c_clear: cover property (@(posedge clk) disable iff (rst)
		cfg_reg[rbt_pkg::BIT_HOLD_CLEAR]);
endmodule : rbt_regbank
`default_nettype wire

/* File: rbt_host.sv */
/*
 Host model: byte register master standing in for the serial host decoder.
 Assumes the bank takes writes and samples the address on the rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module rbt_host (
	input wire logic clk, // Clock
	output logic [6:0] reg_addr, // Register offset
	output logic reg_wr, // Write strobe
	output logic [7:0] reg_wdata, // Write data
	input wire logic [7:0] reg_rdata // Registered read data
);
	initial begin
		reg_addr = 7'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////
	// Requests change only at the falling edge, clear of the sampling edge
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wr = 1'b1;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
		// Stale data inverted so a late sample cannot pass by luck
		reg_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		@(negedge clk);
		d = reg_rdata;
	endtask : rd
endmodule : rbt_host
`default_nettype wire

/* File: rbt_regbank_tb.sv */
/*
 Self-checking bench for the mask bank and button hold timer.
 Assumes short second and debounce counts set through parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module rbt_regbank_tb;
	localparam int SEC = 8;
	logic clk, rst, button_n, ot_ev, rf_ev, mon_p, sup_p, btn_p;
	logic clr_f, clr_o, clr_r, fo_flag, ot_flag, rf_flag, emr, irq;
	logic reg_wr;
	logic [6:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d;
	logic [7:0] gb [3] = '{8'h20, 8'h04, 8'h01};
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
	rbt_regbank #(.SECOND_CYC(SEC), .DEBOUNCE_CYC(4)) u_rbt_regbank (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .button_n(button_n),
		.overtemp_event(ot_ev), .regfault_event(rf_ev),
		.monitor_group_pend(mon_p), .supply_group_pend(sup_p),
		.button_group_pend(btn_p), .flag_clear_forced(clr_f),
		.flag_clear_overtemp(clr_o), .flag_clear_regfault(clr_r),
		.button_forced_reset_flag(fo_flag), .overtemp_shutdown_flag(ot_flag),
		.regulator_fault_flag(rf_flag), .emergency_reset(emr), .irq(irq));
	rbt_host u_rbt_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict
	task automatic chk_rd(input logic [6:0] a, input logic [7:0] e);
		u_rbt_host.rd(a, d);
		`CHK(d, e)
	endtask : chk_rd
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst, button_n} = 2'b11;
		{ot_ev, rf_ev, mon_p, sup_p, btn_p, clr_f, clr_o, clr_r} = 8'h00;
		repeat (5) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		chk_rd(7'h11, 8'h30);
		chk_rd(7'h12, 8'h02);
		chk_rd(7'h13, 8'ha5);
		chk_rd(7'h14, 8'h1f);
		chk_rd(7'h15, 8'h40);
		for (int i = 0; i < 3; i++) begin
			u_rbt_host.wr(7'h13, 8'hff);
			{mon_p, sup_p, btn_p} = 3'b100 >> i;
			@(negedge clk);
			`CHK(irq, 1'b0)
			u_rbt_host.wr(7'h13, ~gb[i]);
			`CHK(irq, 1'b1)
		end
		{mon_p, sup_p, btn_p} = 3'b000;
		u_rbt_host.wr(7'h11, 8'hff);
		chk_rd(7'h11, 8'h30);
		u_rbt_host.wr(7'h12, 8'hff);
		chk_rd(7'h12, 8'h02);
		u_rbt_host.wr(7'h14, 8'h3f);
		chk_rd(7'h14, 8'h3f);
		u_rbt_host.wr(7'h15, 8'hff);
		chk_rd(7'h15, 8'h40);
		chk_rd(7'h20, 8'h00);
		// Reset group open, overtemp still masked
		u_rbt_host.wr(7'h13, 8'h7f);
		chk_rd(7'h13, 8'h25);
		@(negedge clk);
		ot_ev = 1'b1;
		@(negedge clk);
		ot_ev = 1'b0;
		`CHK(ot_flag, 1'b1)
		`CHK(emr, 1'b1)
		`CHK(irq, 1'b0)
		u_rbt_host.wr(7'h12, 8'h00);
		`CHK(irq, 1'b1)
		clr_o = 1'b1;
		@(negedge clk);
		clr_o = 1'b0;
		`CHK(irq, 1'b0)
		// Regulator fault: recorded while masked, set wins over clear
		rf_ev = 1'b1;
		@(negedge clk);
		rf_ev = 1'b0;
		`CHK(rf_flag, 1'b1)
		`CHK(irq, 1'b0)
		u_rbt_host.wr(7'h11, 8'h20);
		`CHK(irq, 1'b1)
		u_rbt_host.wr(7'h13, 8'ha5);
		`CHK(irq, 1'b0)
		u_rbt_host.wr(7'h13, 8'h25);
		`CHK(irq, 1'b1)
		{rf_ev, clr_r} = 2'b11;
		@(negedge clk);
		rf_ev = 1'b0;
		`CHK(rf_flag, 1'b1)
		@(negedge clk);
		clr_r = 1'b0;
		`CHK(rf_flag, 1'b0)
		`CHK(irq, 1'b0)
		// Hold trip with bypass and a one second threshold
		u_rbt_host.wr(7'h11, 8'h00);
		u_rbt_host.wr(7'h14, 8'h81);
		button_n = 1'b0;
		n = 0;
		while (emr !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		`CHK(n inside {[8:12]}, 1'b1)
		`CHK(fo_flag, 1'b1)
		`CHK(irq, 1'b1)
		@(negedge clk);
		`CHK(emr, 1'b0)
		chk_rd(7'h15, 8'h01);
		u_rbt_host.wr(7'h14, 8'hc1);
		chk_rd(7'h14, 8'h81);
		chk_rd(7'h15, 8'h00);
		button_n = 1'b1;
		repeat (2) @(negedge clk);
		chk_rd(7'h15, 8'h40);
		clr_f = 1'b1;
		@(negedge clk);
		clr_f = 1'b0;
		`CHK(fo_flag, 1'b0)
		`CHK(irq, 1'b0)
		// Debounced: a short glitch is ignored, a longer hold is seen
		u_rbt_host.wr(7'h14, 8'h1f);
		button_n = 1'b0;
		repeat (2) @(negedge clk);
		button_n = 1'b1;
		chk_rd(7'h15, 8'h40);
		button_n = 1'b0;
		repeat (7) @(negedge clk);
		chk_rd(7'h15, 8'h00);
		button_n = 1'b1;
		give_verdict();
	end
endmodule : rbt_regbank_tb
`default_nettype wire
